// [inc/fdhp_pkg.sv]
// Shared constants and types for the flash disk host bus port.
package fdhp_pkg;
  localparam int ADDR_W = 15;
  localparam int HADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LOC_W = 13;
  localparam int BYTE_W = 8;
  localparam int N_SRC = 4;
  localparam int BOOT_WORDS = 8;
  localparam int BOOT_IDX_W = 3;
  localparam int BOOT_IDX_LSB = 1;
  localparam int BOOT_SPAN_LSB = 4;
  // Device-local byte addresses of the control words.
  localparam logic [LOC_W-1:0] OFS_ENDIAN = 13'h1000;
  localparam logic [LOC_W-1:0] OFS_IRQ_CTRL = 13'h1002;
  localparam logic [LOC_W-1:0] OFS_IRQ_STAT = 13'h1004;
  localparam logic [LOC_W-1:0] OFS_FLASH_LO = 13'h1006;
  localparam logic [LOC_W-1:0] OFS_FLASH_HI = 13'h1008;
  // Field positions of the endian and interrupt control words.
  localparam int END_SWAP_LOW_BYTES = 0;
  localparam int END_SWAP_HIGH_BYTES = 1;
  localparam int IRQC_EN = 0;
  localparam int IRQC_LEVEL = 1;
  localparam int IRQC_SRC_LSB = 2;
  localparam int IRQC_W = 6;
  localparam logic [1:0] END_RST = 2'h0;
  localparam logic [IRQC_W-1:0] IRQC_RST = 6'h00;
  localparam logic [1:0] STRAP_FIRST = 2'h0;
  // Host controller register indices and fields.
  localparam logic [2:0] HR_ADDR = 3'h0;
  localparam logic [2:0] HR_WDATA = 3'h1;
  localparam logic [2:0] HR_START = 3'h2;
  localparam logic [2:0] HR_RDATA = 3'h3;
  localparam logic [2:0] HR_STATUS = 3'h4;
  localparam logic [2:0] HR_CONFIG = 3'h5;
  localparam int ST_READ = 0;
  localparam int STS_INIT_BUSY = 0;
  localparam int STS_CYC_BUSY = 1;
  localparam int STS_IRQ = 2;
  localparam int CFG_WIDE = 0;
  localparam int CFG_DWORD = 1;
  localparam int CFG_MUX = 2;
  localparam int CFG_IRQ_EDGE = 3;
  localparam logic [3:0] CFG_RST = 4'h1;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_STRB = 2'b10,
    H_HOLD = 2'b11
  } fdhp_hst_t;
  typedef enum logic {
    D_LOAD = 1'b0,
    D_READY = 1'b1
  } fdhp_dev_t;
endpackage : fdhp_pkg

// [inc/fdhp_bus_if.sv]
// Pin-level bus between the host controller and the flash disk device.
`timescale 1ns/10ps
`default_nettype none
interface fdhp_bus_if;
  import fdhp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_dq;
  logic [1:0] host_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic [1:0] dev_dq_oe;
  logic hi_pullup;
  logic [DATA_W-1:0] dq;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic width_sel;
  logic [1:0] strap_position;
  logic por_n;
  logic init_busy_n;
  logic irq_n;
  // Resolved data lanes; an undriven upper lane floats high under pull-up.
  assign dq[7:0] = dev_dq_oe[0] ? dev_dq[7:0] :
                   host_dq_oe[0] ? host_dq[7:0] : 8'h00;
  assign dq[15:8] = dev_dq_oe[1] ? dev_dq[15:8] :
                    host_dq_oe[1] ? host_dq[15:8] :
                    hi_pullup ? 8'hFF : 8'h00;
  modport host (output addr, host_dq, host_dq_oe, ce_n, oe_n, we_n,
                width_sel, strap_position, por_n,
                input dq, init_busy_n, irq_n);
  modport dev (input addr, dq, ce_n, oe_n, we_n, width_sel,
               strap_position, por_n,
               output dev_dq, dev_dq_oe, hi_pullup, init_busy_n, irq_n);
endinterface : fdhp_bus_if
`default_nettype wire

// [src/fdhp_device.sv]
// Device end of the flash disk host bus port.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1 - two strap bits give cascade position
// RULE2 - board straps single device 00, then consecutively
// RULE3 - multiplexed mode reads upper strap as zero
// RULE4 - each cascaded boot block has own range
// RULE5 - low lane is least significant byte
// RULE6 - both swap bits exchange lanes on words
// RULE7 - busy held until loader and protection loaded
// RULE8 - host waits for busy release
// RULE9 - sixteen-bit data bus by default
// RULE10 - upper lane pulled up in byte mode
// RULE11 - byte mode routes even/odd to lanes
// RULE12 - decode address bit0 with width select
// RULE13 - boot block behaves as true word memory
// RULE14 - flash area accessed as 16/32-bit resource
// RULE15 - dword-only host shifts address by one
// RULE16 - interrupt sources selected by control word
// RULE17 - edge or level interrupt signalling selectable
// RULE18 - host matches interrupt sensitivity
// RULE19 - interrupt raised only while enabled
// RULE20 - upper strap falling edge enters multiplexed mode; here only until the first read strobe after reset
// RULE21 - width select low byte, high word
// RULE22 - level interrupt held until cause cleared
// RULE23 - respond only inside own strap range
module fdhp_device (
  input wire logic clk_sys,
  input wire logic rst_n,
  fdhp_bus_if.dev bus,
  input wire logic ld_we,
  input wire logic [fdhp_pkg::BOOT_IDX_W-1:0] ld_idx,
  input wire logic [fdhp_pkg::DATA_W-1:0] ld_data,
  input wire logic ipl_done,
  input wire logic dps_done,
  input wire logic [fdhp_pkg::N_SRC-1:0] evt,
  input wire logic [2*fdhp_pkg::DATA_W-1:0] flash_rd_data,
  output logic flash_wr_valid,
  output logic [2*fdhp_pkg::DATA_W-1:0] flash_wr_data,
  output logic mux_mode
);
  import fdhp_pkg::*;

  logic rst_ok;
  fdhp_dev_t state_q, state_d;
  logic ipl_seen_q, dps_seen_q;
  logic strap1_q, mux_q, rd_seen_q;
  logic [ADDR_W-1:0] addr_lat_q;
  logic [1:0] swap_q;
  logic [IRQC_W-1:0] irqc_q;
  logic [N_SRC-1:0] stat_q, stat_clr;
  logic [DATA_W-1:0] boot_q [BOOT_WORDS];
  logic [DATA_W-1:0] flash_lo_q, flash_hold_q;
  logic [DATA_W-1:0] dq_q;
  logic [1:0] oe_q;
  logic irq_n_q, busy_n_q;
  logic fwv_q;
  logic [2*DATA_W-1:0] fwd_q;
  logic strap_fall, ready;
  logic [1:0] strap_eff;
  logic [ADDR_W-1:0] cur_addr;
  logic [LOC_W-1:0] loc;
  logic a0, wide, sel, illegal, rd, wr, any_rd;
  logic hit_boot, hit_end, hit_irqc, hit_stat, hit_flo, hit_fhi;
  logic [BOOT_IDX_W-1:0] idx;
  logic [DATA_W-1:0] rword, rd_out, wr_in, swapped_in;
  logic swap;
  logic [N_SRC-1:0] src_mask;
  logic pend, fresh, irq_d;
  logic mux_d;

  // A power-on reset from the host resets the port like the local reset.
  assign rst_ok = rst_n & bus.por_n;

  // Multiplexed mode and effective cascade position.
  assign strap_fall = strap1_q & ~bus.strap_position[1];
  // The entering strobe already carries the first address to latch.
  assign mux_d = mux_q | (strap_fall & ~rd_seen_q); // RULE20
  assign strap_eff = mux_q ? {1'b0, bus.strap_position[0]}  // RULE3
                           : bus.strap_position;           // RULE1
  assign cur_addr = mux_q ? addr_lat_q : bus.addr;
  assign loc = cur_addr[LOC_W-1:0];
  assign a0 = loc[0];
  assign wide = bus.width_sel; // RULE21 RULE9

  // Address decode; the position bits sit above the local window.
  assign sel = (cur_addr[ADDR_W-1:LOC_W] == strap_eff); // RULE23 RULE4
  assign illegal = a0 & wide; // RULE12
  assign ready = (state_q == D_READY);
  assign any_rd = ~bus.ce_n & ~bus.oe_n;
  assign rd = any_rd & sel & ready & ~illegal;
  assign wr = ~bus.ce_n & ~bus.we_n & bus.oe_n & sel & ready & ~illegal;
  assign hit_boot = (loc[LOC_W-1:BOOT_SPAN_LSB] == '0);
  assign hit_end = (loc[LOC_W-1:1] == OFS_ENDIAN[LOC_W-1:1]);
  assign hit_irqc = (loc[LOC_W-1:1] == OFS_IRQ_CTRL[LOC_W-1:1]);
  assign hit_stat = (loc[LOC_W-1:1] == OFS_IRQ_STAT[LOC_W-1:1]);
  assign hit_flo = (loc[LOC_W-1:1] == OFS_FLASH_LO[LOC_W-1:1]);
  assign hit_fhi = (loc[LOC_W-1:1] == OFS_FLASH_HI[LOC_W-1:1]);
  assign idx = loc[BOOT_IDX_LSB +: BOOT_IDX_W];

  // Word seen at the addressed location, before lane formatting.
  assign rword = hit_boot ? boot_q[idx] : // RULE13
                 hit_end ? {14'h0000, swap_q} :
                 hit_irqc ? {10'h000, irqc_q} :
                 hit_stat ? {12'h000, stat_q} :
                 hit_flo ? flash_rd_data[DATA_W-1:0] : // RULE14
                 hit_fhi ? flash_hold_q : 16'h0000;

  // Lane steering: low lane is the low byte, bytes go out on lane 0.
  assign swap = swap_q[END_SWAP_HIGH_BYTES] & swap_q[END_SWAP_LOW_BYTES] & wide; // RULE6
  assign rd_out = !wide ? {8'h00, a0 ? rword[15:8] : rword[7:0]} // RULE11
                : swap ? {rword[7:0], rword[15:8]} // RULE6
                : rword; // RULE5
  assign swapped_in = {bus.dq[7:0], bus.dq[15:8]};
  assign wr_in = !wide ? (a0 ? {bus.dq[7:0], rword[7:0]} // RULE11
                             : {rword[15:8], bus.dq[7:0]})
               : swap ? swapped_in : bus.dq; // RULE5

  // Interrupt source selection and output shaping.
  assign src_mask = irqc_q[IRQC_SRC_LSB +: N_SRC]; // RULE16
  assign pend = |(stat_q & src_mask);
  assign fresh = |(evt & src_mask);
  assign irq_d = irqc_q[IRQC_LEVEL] ? ~(irqc_q[IRQC_EN] & pend) // RULE22
                                    : ~(irqc_q[IRQC_EN] & fresh); // RULE17
  assign stat_clr = (wr & hit_stat) ? wr_in[N_SRC-1:0] : '0;

  // Upper lane pull-up follows the width strap.
  assign bus.hi_pullup = ~bus.width_sel; // RULE10
  assign bus.dev_dq = dq_q;
  assign bus.dev_dq_oe = oe_q;
  assign bus.irq_n = irq_n_q;
  assign bus.init_busy_n = busy_n_q;
  assign flash_wr_valid = fwv_q;
  assign flash_wr_data = fwd_q;
  assign mux_mode = mux_q;

  // Initialisation sequencing: loader and protection loads both finish.
  always_comb begin
    state_d = state_q;
    case (state_q)
      D_LOAD: begin
        if ((ipl_seen_q | ipl_done) & (dps_seen_q | dps_done)) begin
          state_d = D_READY;
        end
      end
      D_READY: state_d = D_READY;
      default: state_d = D_LOAD;
    endcase
  end

  // Initialisation flops and the busy output.
  always_ff @(posedge clk_sys) begin
    if (!rst_ok) begin
      state_q <= D_LOAD;
      ipl_seen_q <= 1'b0;
      dps_seen_q <= 1'b0;
      busy_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ipl_seen_q <= ipl_seen_q | ipl_done;
      dps_seen_q <= dps_seen_q | dps_done;
      busy_n_q <= (state_d == D_READY); // RULE7
    end
  end

  // Multiplexed-mode entry and address latch.
  always_ff @(posedge clk_sys) begin
    if (!rst_ok) begin
      strap1_q <= 1'b0;
      mux_q <= 1'b0;
      rd_seen_q <= 1'b0;
      addr_lat_q <= '0;
    end else begin
      strap1_q <= bus.strap_position[1];
      mux_q <= mux_d; // RULE20
      rd_seen_q <= rd_seen_q | any_rd;
      if (mux_d & ~bus.strap_position[1]) begin
        addr_lat_q <= bus.dq[ADDR_W-1:0];
      end
    end
  end

  // Control words written by the host.
  always_ff @(posedge clk_sys) begin
    if (!rst_ok) begin
      swap_q <= END_RST;
      irqc_q <= IRQC_RST;
      stat_q <= '0;
    end else begin
      if (wr & hit_end) begin
        swap_q <= wr_in[1:0];
      end
      if (wr & hit_irqc) begin
        irqc_q <= wr_in[IRQC_W-1:0]; // RULE19
      end
      stat_q <= (stat_q & ~stat_clr) | evt; // RULE22
    end
  end

  // Boot block storage, filled by the loader then written by the host.
  always_ff @(posedge clk_sys) begin
    if (ld_we & ~ready) begin
      boot_q[ld_idx] <= ld_data; // RULE7
    end else if (wr & hit_boot) begin
      boot_q[idx] <= wr_in; // RULE13
    end
  end

  // Flash window: words pair into double words, low half first.
  always_ff @(posedge clk_sys) begin
    if (!rst_ok) begin
      flash_lo_q <= '0;
      flash_hold_q <= '0;
      fwv_q <= 1'b0;
      fwd_q <= '0;
    end else begin
      fwv_q <= wr & hit_fhi; // RULE14
      if (wr & hit_flo) begin
        flash_lo_q <= wr_in;
      end
      if (wr & hit_fhi) begin
        fwd_q <= {wr_in, flash_lo_q};
      end
      if (rd & hit_flo) begin
        flash_hold_q <= flash_rd_data[2*DATA_W-1:DATA_W];
      end
    end
  end

  // Read data stands for the one cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (!rst_ok) begin
      dq_q <= '0;
      oe_q <= 2'b00;
      irq_n_q <= 1'b1;
    end else begin
      dq_q <= rd ? rd_out : dq_q;
      oe_q <= rd ? {wide, 1'b1} : 2'b00; // RULE23 RULE9
      irq_n_q <= irq_d; // RULE19
    end
  end
endmodule : fdhp_device
`default_nettype wire

// [src/fdhp_host.sv]
// Host end of the flash disk host bus port, driven through a register port.
`timescale 1ns/10ps
`default_nettype none
module fdhp_host #(
  parameter logic [1:0] STRAP_POS = fdhp_pkg::STRAP_FIRST
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  fdhp_bus_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [fdhp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [fdhp_pkg::DATA_W-1:0] reg_rdata
);
  import fdhp_pkg::*;

  fdhp_hst_t state_q, state_d;
  logic [HADDR_W-1:0] haddr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q, reg_rdata_q;
  logic [3:0] cfg_q;
  logic is_wr_q, pend_q, por_q, irq_flag_q, irq_prev_q;
  logic start_wr, start_rd, go, idle, irq_fall, irq_seen, irq_clr;
  logic [ADDR_W-1:0] dev_addr;
  logic [DATA_W-1:0] status;

  // Register port decode; starts are refused while a cycle is open.
  assign idle = (state_q == H_IDLE) & ~pend_q;
  assign start_wr = reg_we & (reg_addr == HR_WDATA) & idle;
  assign start_rd = reg_we & (reg_addr == HR_START) & reg_wdata[ST_READ]
                    & idle;
  assign irq_clr = reg_we & (reg_addr == HR_STATUS) & reg_wdata[STS_IRQ];
  assign go = pend_q & bus.init_busy_n; // RULE8

  // Double-word hosts tie bit 0 low and feed bit 1 from address bit 2.
  assign dev_addr = cfg_q[CFG_DWORD] ? {haddr_q[HADDR_W-1:2], 1'b0} // RULE15
                                     : haddr_q[ADDR_W-1:0];

  // Edge mode latches each falling edge; level mode shows the pin.
  assign irq_fall = irq_prev_q & ~bus.irq_n;
  assign irq_seen = cfg_q[CFG_IRQ_EDGE] ? irq_flag_q : ~bus.irq_n; // RULE18
  assign status = {13'h0000, irq_seen, ~idle, ~bus.init_busy_n};

  // Pin drive follows the cycle state.
  assign bus.addr = dev_addr;
  assign bus.host_dq = (state_q == H_ADDR) ? {1'b0, dev_addr} : wdata_q;
  assign bus.host_dq_oe = ((state_q == H_ADDR) |
                           ((state_q == H_STRB) & is_wr_q)) ?
                          {cfg_q[CFG_WIDE], 1'b1} : 2'b00;
  assign bus.ce_n = (state_q != H_STRB);
  assign bus.oe_n = ~((state_q == H_STRB) & ~is_wr_q);
  assign bus.we_n = ~((state_q == H_STRB) & is_wr_q);
  assign bus.width_sel = cfg_q[CFG_WIDE];
  assign bus.strap_position = {cfg_q[CFG_MUX] ? (state_q != H_ADDR) // RULE3
                                              : STRAP_POS[1],
                               STRAP_POS[0]}; // RULE2
  assign bus.por_n = por_q;
  assign reg_rdata = reg_rdata_q;

  // Bus cycle sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      H_IDLE: begin
        if (go) begin
          state_d = cfg_q[CFG_MUX] ? H_ADDR : H_STRB;
        end
      end
      H_ADDR: state_d = H_STRB;
      H_STRB: state_d = H_HOLD;
      H_HOLD: state_d = H_IDLE;
      default: state_d = H_IDLE;
    endcase
  end

  // Cycle state, captured read data and the power-on reset pin.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      pend_q <= 1'b0;
      is_wr_q <= 1'b0;
      rdata_q <= '0;
      por_q <= 1'b0;
    end else begin
      state_q <= state_d;
      por_q <= 1'b1;
      pend_q <= (pend_q & ~go) | start_wr | start_rd;
      if (start_wr | start_rd) begin
        is_wr_q <= start_wr;
      end
      if ((state_q == H_HOLD) & ~is_wr_q) begin
        rdata_q <= bus.dq;
      end
    end
  end

  // Software-visible registers; a new edge beats a clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      haddr_q <= '0;
      wdata_q <= '0;
      cfg_q <= CFG_RST;
      irq_flag_q <= 1'b0;
      irq_prev_q <= 1'b1;
      reg_rdata_q <= '0;
    end else begin
      irq_prev_q <= bus.irq_n;
      irq_flag_q <= (irq_flag_q & ~irq_clr) | irq_fall;
      if (reg_we & (reg_addr == HR_ADDR)) begin
        haddr_q <= reg_wdata;
      end
      if (start_wr) begin
        wdata_q <= reg_wdata;
      end
      if (reg_we & (reg_addr == HR_CONFIG) & idle) begin
        cfg_q <= reg_wdata[3:0];
      end
      if (reg_re) begin
        case (reg_addr)
          HR_ADDR: reg_rdata_q <= haddr_q;
          HR_WDATA: reg_rdata_q <= wdata_q;
          HR_RDATA: reg_rdata_q <= rdata_q;
          HR_STATUS: reg_rdata_q <= status;
          HR_CONFIG: reg_rdata_q <= {12'h000, cfg_q};
          default: reg_rdata_q <= '0;
        endcase
      end
    end
  end
endmodule : fdhp_host
`default_nettype wire

// [verification/fdhp_bus_sva.sv]
// Checker for the wires between the host and device ends.
`timescale 1ns/10ps
`default_nettype none
module fdhp_bus_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [fdhp_pkg::ADDR_W-1:0] addr,
  input wire logic [1:0] dev_dq_oe,
  input wire logic hi_pullup,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic width_sel,
  input wire logic [1:0] strap_position,
  input wire logic por_n,
  input wire logic init_busy_n
);
  logic mux_q;
  wire rd_w;
  // Tracks multiplexed mode, where the address comes over the data lines.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !por_n) begin
      mux_q <= 1'b0;
    end else if ($fell(strap_position[1])) begin
      mux_q <= 1'b1;
    end
  end
  // A plain read strobe outside multiplexed mode.
  assign rd_w = !ce_n && !oe_n && !mux_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd_own;
    rd_w && init_busy_n && addr[14:13] == strap_position
      && !(addr[0] && width_sel) && addr[12:4] == 9'h000;
  endsequence
  chk_busy_reset: assert property (!por_n |=> !init_busy_n)
    else $error("busy not asserted after power-on reset");
  chk_busy_stays: assert property (init_busy_n && por_n |=> init_busy_n)
    else $error("busy asserted again without reset");
  chk_read_answer: assert property (s_rd_own |=> dev_dq_oe == {width_sel, 1'b1})
    else $error("read lanes wrong for width select");
  chk_no_foreign: assert property (rd_w && addr[14:13] != strap_position |=> dev_dq_oe == 2'h0)
    else $error("device drove a read of another position");
  chk_illegal_quiet: assert property (rd_w && addr[0] && width_sel |=> dev_dq_oe == 2'h0)
    else $error("device drove an illegal odd word read");
  chk_pullup_mode: assert property (hi_pullup == !width_sel)
    else $error("upper lane pull-up not tied to byte mode");
  chk_oe_cause: assert property (dev_dq_oe != 2'h0 |-> $past(ce_n) == 1'b0 && $past(oe_n) == 1'b0)
    else $error("data driven without a read strobe");
  chk_write_quiet: assert property (!ce_n && !we_n && oe_n |=> dev_dq_oe == 2'h0)
    else $error("data driven after a write strobe");
endmodule : fdhp_bus_sva
`default_nettype wire

// [verification/tb_top.sv]
// Bench joining host and device ends through the bus interface.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fdhp_pkg::*;
  localparam logic [1:0] POS = 2'h2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, last, lo, hi;
  logic reg_we = 1'b0, reg_re = 1'b0, ld_we = 1'b0, chk_re = 1'b0;
  logic ipl_done = 1'b0, dps_done = 1'b0, pend_q = 1'b0;
  logic flash_wr_valid, mux_mode;
  logic [2:0] ld_idx = 3'h0;
  logic [15:0] ld_data = 16'h0000;
  logic [3:0] evt = 4'h0;
  logic [31:0] flash_rd_data = 32'h0, flash_wr_data, fr;
  logic [15:0] boot [8];
  logic [15:0] exp_rd [$];
  logic [31:0] exp_fl [$];
  int n_mismatch = 0, total_checks = 0, seed = 32'h34CE, n;
  initial forever #5 clk_sys = ~clk_sys;
  fdhp_bus_if bus ();
  fdhp_host #(.STRAP_POS(POS)) i_fdhp_host (.clk_sys(clk_sys),
    .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  fdhp_device i_fdhp_device (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
    .ld_we(ld_we), .ld_idx(ld_idx), .ld_data(ld_data), .ipl_done(ipl_done),
    .dps_done(dps_done), .evt(evt), .flash_rd_data(flash_rd_data),
    .flash_wr_valid(flash_wr_valid), .flash_wr_data(flash_wr_data),
    .mux_mode(mux_mode));
  fdhp_bus_sva i_fdhp_bus_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .addr(bus.addr), .dev_dq_oe(bus.dev_dq_oe), .hi_pullup(bus.hi_pullup),
    .ce_n(bus.ce_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .width_sel(bus.width_sel), .strap_position(bus.strap_position),
    .por_n(bus.por_n), .init_busy_n(bus.init_busy_n));
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : check
  // Takes the oldest note whenever a checked read word or flash write shows up.
  always @(posedge clk_sys) begin
    pend_q <= reg_re && chk_re;
    if (pend_q) check("reg_rdata", 32'(exp_rd.pop_front()), 32'(reg_rdata));
    if (rst_n === 1'b1 && flash_wr_valid !== 1'b0) begin
      check("flash", exp_fl.pop_front(), flash_wr_data);
    end
  end
  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    @(posedge clk_sys);
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic c,
                        input logic [15:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    chk_re <= c;
    if (c) exp_rd.push_back(e);
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(posedge clk_sys);
    last = reg_rdata;
  endtask : reg_rd
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      reg_rd(HR_STATUS, 1'b0, 16'h0000);
      if (last[STS_CYC_BUSY] === 1'b0) return;
    end
    n_mismatch++;
    print_verdict();
  endtask : wait_idle
  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    reg_wr(HR_ADDR, a);
    reg_wr(HR_WDATA, d);
    wait_idle();
  endtask : bus_wr
  task automatic bus_rd(input logic [15:0] a, input logic [15:0] e);
    reg_wr(HR_ADDR, a);
    reg_wr(HR_START, 16'h0001);
    wait_idle();
    reg_rd(HR_RDATA, 1'b1, e);
  endtask : bus_rd
  function automatic logic [15:0] loc(input logic [1:0] p,
                                      input logic [12:0] o);
    return {1'b0, p, o};
  endfunction : loc
  task automatic pulse(input int s);
    n = 0;
    evt <= 4'h1 << s;
    @(posedge clk_sys);
    evt <= 4'h0;
    repeat (6) begin
      @(posedge clk_sys);
      n += int'(bus.irq_n === 1'b0);
    end
  endtask : pulse
  // Releases reset, loads the boot words and finishes both loads.
  task automatic boot_up();
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      boot[i] = 16'($random(seed));
      ld_we <= 1'b1;
      ld_idx <= 3'(i);
      ld_data <= boot[i];
      @(posedge clk_sys);
    end
    ld_we <= 1'b0;
    ipl_done <= 1'b1;
    reg_rd(HR_STATUS, 1'b1, 16'h0001);
    ipl_done <= 1'b0;
    check("init_busy_n", 1'b0, bus.init_busy_n);
    dps_done <= 1'b1;
    @(posedge clk_sys);
    dps_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("init_busy_n", 1'b1, bus.init_busy_n);
  endtask : boot_up
  initial begin
    boot_up();
    check("mux_mode", 1'b0, mux_mode);
    for (int i = 0; i < 8; i++) bus_rd(loc(POS, 13'(2 * i)), boot[i]);
    bus_rd(loc(2'h1, 13'h0000), 16'h0000);
    bus_rd(loc(POS, 13'h0003), 16'h0000);
    bus_wr(loc(POS, OFS_ENDIAN), 16'h0003);
    bus_rd(loc(POS, 13'h0002), {boot[1][7:0], boot[1][15:8]});
    bus_wr(loc(POS, OFS_ENDIAN), 16'h0101);
    bus_rd(loc(POS, 13'h0002), boot[1]);
    reg_wr(HR_CONFIG, 16'h0000);
    bus_rd(loc(POS, 13'h0004), {8'hFF, boot[2][7:0]});
    bus_rd(loc(POS, 13'h0005), {8'hFF, boot[2][15:8]});
    reg_wr(HR_CONFIG, 16'h0001);
    lo = 16'($random(seed));
    hi = 16'($random(seed));
    fr = $random(seed);
    exp_fl.push_back({hi, lo});
    bus_wr(loc(POS, OFS_FLASH_LO), lo);
    bus_wr(loc(POS, OFS_FLASH_HI), hi);
    flash_rd_data <= fr;
    bus_rd(loc(POS, OFS_FLASH_LO), fr[15:0]);
    flash_rd_data <= ~fr;
    bus_rd(loc(POS, OFS_FLASH_HI), fr[31:16]);
    // Double-word host: device word 5 sits at host byte offset 0x14.
    reg_wr(HR_CONFIG, 16'h0003);
    bus_rd({POS, 14'h0014}, boot[5]);
    // Every source in level and edge signalling, after a pulse on another, masked source.
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        reg_wr(HR_CONFIG, m ? 16'h0001 : 16'h0009);
        bus_wr(loc(POS, OFS_IRQ_STAT), 16'h003F);
        bus_wr(loc(POS, OFS_IRQ_CTRL), (16'h0001 << (s + 2)) | 16'(2 * m + 1));
        pulse((s + 1) % 4);
        check("irq_n masked", 0, n);
        pulse(s);
        if (m) check("irq_n level", 1'b0, bus.irq_n);
        else check("irq_n edge", 1, n);
        reg_rd(HR_STATUS, 1'b1, 16'h0004);
        reg_wr(HR_STATUS, 16'h0004);
      end
    end
    bus_wr(loc(POS, OFS_IRQ_STAT), 16'h003F);
    repeat (3) @(posedge clk_sys);
    check("irq_n cleared", 1'b1, bus.irq_n);
    bus_wr(loc(POS, OFS_IRQ_CTRL), 16'h0006);
    pulse(0);
    check("irq_n disabled", 0, n);
    rst_n <= 1'b0;
    boot_up();
    reg_wr(HR_CONFIG, 16'h0005);
    bus_rd(loc(2'h0, 13'h0006), boot[3]);
    check("mux_mode", 1'b1, mux_mode);
    repeat (3) @(posedge clk_sys);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
